// *** hw/remote_temp_regs.sv ***
// Purpose: AXI4-Lite register block for remote temperature readings and offset.
// Assumes: conv_valid_i pulses once per finished conversion with conv_raw_i valid.
// Notes: Reading a high byte freezes the matching low byte for a coherent pair.
`timescale 1ns/1ps
module remote_temp_regs
  import remote_temp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Converter side
  input wire logic conv_valid_i,
  input wire logic [RAW_W-1:0] conv_raw_i,
  // Write address channel
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [AXI_ADDR_W-1:0] awaddr_i,
  input wire logic [2:0] awprot_i,
  // Write data channel
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [AXI_DATA_W-1:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // Write response channel
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // Read address channel
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [AXI_ADDR_W-1:0] araddr_i,
  input wire logic [2:0] arprot_i,
  // Read data channel
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [AXI_DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o
);

  state_t st;                         // Registered state
  state_t next_st;                    // Next state
  temp_pair_t fmt;                    // Corrected readings of the current raw word
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic [5:0] ar_idx;
  logic [5:0] aw_idx;

  // Offset correction and formatting
  temp_format #(
    .RAW_BITS(RAW_W),
    .OUT_BITS(TEMP_W),
    .OFS_BITS(OFS_W)
  ) u_format (
    .raw_i(conv_raw_i),
    .offset_i({st.ofs_hi, st.ofs_lo}),
    .filt_en_i(st.filt_en),
    .pair_o(fmt)
  );

  // Read value of one register index, bits above the byte read as zero
  function automatic logic [7:0] read_byte(input logic [5:0] idx, input state_t s);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      IDX_SGN_HI: v = s.rd.sgn[TEMP_W-1:INT_LSB];
      IDX_SGN_LO: v = s.sgn_lo_snap;
      IDX_OFS_HI: v = s.ofs_hi;
      IDX_OFS_LO: v = {3'b000, s.ofs_lo, 2'b00};
      IDX_UNS_HI: v = s.rd.uns[TEMP_W-1:INT_LSB];
      IDX_UNS_LO: v = s.uns_lo_snap;
      IDX_CTRL: v = {7'h00, s.filt_en};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // True when an index names a register at all
  function automatic logic is_mapped(input logic [5:0] idx);
    return idx == IDX_SGN_HI || idx == IDX_SGN_LO || idx == IDX_OFS_HI ||
           idx == IDX_OFS_LO || idx == IDX_UNS_HI || idx == IDX_UNS_LO || idx == IDX_CTRL;
  endfunction

  assign aw_fire = awvalid_i && st.awready;
  assign w_fire = wvalid_i && st.wready;
  assign ar_fire = arvalid_i && st.arready;
  assign ar_idx = araddr_i[7:2];

  // Next-state logic for bus, registers and readings
  always_comb begin
    next_st = st;
    aw_idx = st.aw_addr[7:2];
    // Response channels drop once taken
    if (st.bvalid && bready_i) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && rready_i) begin
      next_st.rvalid = 1'b0;
    end
    // Capture address and data independently, in either order
    if (aw_fire) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr_i;
      aw_idx = awaddr_i[7:2];
    end
    if (w_fire) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata_i[7:0];
      next_st.w_lane = wstrb_i[0];
    end
    // Perform the write once both halves are in
    if (next_st.aw_held && next_st.w_held && !next_st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
      // Only lane zero carries register bits; other lanes are ignored
      if (next_st.w_lane) begin
        unique case (aw_idx)
          IDX_OFS_HI: next_st.ofs_hi = next_st.w_data;
          IDX_OFS_LO: next_st.ofs_lo = next_st.w_data[OFS_LO_LSB+2:OFS_LO_LSB];
          IDX_CTRL: next_st.filt_en = next_st.w_data[CTRL_FILT_BIT];
          default: begin
            // Readings are read-only and unmapped words hold nothing
          end
        endcase
      end
    end
    // Read: data from the current state, so a pair never straddles an update
    if (ar_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = {24'h000000, read_byte(ar_idx, st)};
      next_st.rresp = is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      // High-byte read freezes its low byte, relying on high-first order
      if (ar_idx == IDX_UNS_HI) begin
        next_st.uns_lo_snap = {3'b000, st.rd.uns[FRAC_MSB:0]};
      end
      if (ar_idx == IDX_SGN_HI) begin
        next_st.sgn_lo_snap = {3'b000, st.rd.sgn[FRAC_MSB:0]};
      end
    end
    // Both forms come from the same corrected result, same edge
    if (conv_valid_i) begin
      next_st.rd = fmt;
    end
    // Ready flags: one outstanding item per channel
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  // State register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.ofs_hi <= OFS_HI_RST;
      st.ofs_lo <= OFS_LO_RST;
      st.filt_en <= CTRL_FILT_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign awready_o = st.awready;
  assign wready_o = st.wready;
  assign bvalid_o = st.bvalid;
  assign bresp_o = st.bresp;
  assign arready_o = st.arready;
  assign rvalid_o = st.rvalid;
  assign rdata_o = st.rdata;
  assign rresp_o = st.rresp;

  // Readings follow the conversion on the next edge
  unsigned_update_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    conv_valid_i |=> st.rd.uns == $past(fmt.uns) && st.rd.sgn == $past(fmt.sgn))
    else $error("readings not updated together");

  // Filter off clears the two lowest bits
  filter_off_zero_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    conv_valid_i && !st.filt_en |=> st.rd.uns[1:0] == 2'b00 && st.rd.sgn[1:0] == 2'b00)
    else $error("low bits not zero with filter off");

  // Filter on passes the fine fraction through
  filter_on_pass_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    conv_valid_i && st.filt_en && fmt.uns != 13'h0000 && fmt.uns != 13'h1FFF
    |=> st.rd.uns[1:0] == $past(conv_raw_i[1:0]))
    else $error("fine fraction lost with filter on");

  // Zero offset leaves an in-range raw value unchanged
  offset_zero_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    conv_valid_i && st.filt_en && st.ofs_hi == 8'h00 && st.ofs_lo == 3'h0 &&
    conv_raw_i[RAW_W-1] == conv_raw_i[RAW_W-2]
    |=> st.rd.sgn == $past(conv_raw_i[TEMP_W-1:0]))
    else $error("zero offset changed the reading");

  // Unsigned high byte returns the integer part
  unsigned_high_read_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ar_fire && ar_idx == IDX_UNS_HI
    |=> rvalid_o && rdata_o == {24'h000000, $past(st.rd.uns[TEMP_W-1:INT_LSB])})
    else $error("unsigned high byte wrong");

  // Unsigned high-byte read freezes the matching low byte
  pair_snapshot_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ar_fire && ar_idx == IDX_UNS_HI
    |=> st.uns_lo_snap == {3'b000, $past(st.rd.uns[FRAC_MSB:0])})
    else $error("low byte not frozen at high read");

  // Unsigned low byte returns the frozen fraction
  unsigned_low_read_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ar_fire && ar_idx == IDX_UNS_LO |=> rdata_o == {24'h000000, $past(st.uns_lo_snap)})
    else $error("unsigned low byte wrong");

  // A negative signed reading means the unsigned one is zero
  sign_unsigned_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    st.rd.sgn[TEMP_W-1] |-> st.rd.uns == 13'h0000)
    else $error("sign and unsigned reading disagree");

  // Offset low byte layout on read back
  offset_low_read_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ar_fire && ar_idx == IDX_OFS_LO
    |=> rdata_o == {24'h000000, 3'b000, $past(st.ofs_lo), 2'b00})
    else $error("offset low byte layout wrong");

  // Write response holds until taken
  bresp_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped early");

  // Address and data are refused while a response waits
  write_ready_gate_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    bvalid_o |-> !awready_o && !wready_o)
    else $error("write channel ready while response waits");

  // Address channel is refused while read data wait
  read_ready_gate_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rvalid_o |-> !arready_o)
    else $error("read address ready while data wait");

  // Read data and answer code stand until taken
  read_data_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o) && $stable(rresp_o))
    else $error("read data dropped early");

  // Address and data taken together are answered on the next edge
  write_answer_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    aw_fire && w_fire |=> bvalid_o)
    else $error("write not answered");

  // Offset high byte takes lane zero of the written word
  offset_high_write_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    aw_fire && w_fire && wstrb_i[0] && awaddr_i[7:2] == IDX_OFS_HI
    |=> st.ofs_hi == $past(wdata_i[7:0]))
    else $error("offset high byte not written");

  // Offset low byte takes bits 4..2 of lane zero, the rest is dropped
  offset_low_write_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    aw_fire && w_fire && wstrb_i[0] && awaddr_i[7:2] == IDX_OFS_LO
    |=> st.ofs_lo == $past(wdata_i[OFS_LO_LSB+2:OFS_LO_LSB]))
    else $error("offset low byte not written");

  // Filter enable follows a write of the control word
  filter_write_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    aw_fire && w_fire && wstrb_i[0] && awaddr_i[7:2] == IDX_CTRL
    |=> st.filt_en == $past(wdata_i[CTRL_FILT_BIT]))
    else $error("filter enable not written");

  // Unmapped places read as zero with an error code
  unmapped_read_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ar_fire && !is_mapped(ar_idx) |=> rresp_o == RESP_SLVERR && rdata_o == 32'h00000000)
    else $error("unmapped read not refused");

  // Signed high byte returns the sign and integer part
  signed_high_read_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ar_fire && ar_idx == IDX_SGN_HI
    |=> rdata_o == {24'h000000, $past(st.rd.sgn[TEMP_W-1:INT_LSB])})
    else $error("signed high byte wrong");

  // A positive unclipped reading has the same bits in both forms
  form_match_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !st.rd.sgn[TEMP_W-1] && st.rd.sgn[TEMP_W-2:2] != 10'h3FF |-> st.rd.uns == st.rd.sgn)
    else $error("unsigned and signed forms disagree");

endmodule

// *** hw/remote_temp_pkg.sv ***
// Purpose: Shared constants and types for the remote temperature result and offset block.
// Assumes: One 50 MHz clock, synchronous active-low reset, AXI4-Lite register access.
// Notes: Register indices are word indices; byte address is four times the index.
package remote_temp_pkg;

  // Data widths of the measurement path
  localparam int RAW_W = 14;          // Raw converter word, signed, 1/32 degree per step
  localparam int TEMP_W = 13;         // Reading word: eight integer and five fraction bits
  localparam int OFS_W = 11;          // Offset word: eight integer and three fraction bits
  localparam int AXI_ADDR_W = 8;      // Enough for the highest word index
  localparam int AXI_DATA_W = 32;

  // Word indices of the registers
  localparam logic [5:0] IDX_SGN_HI = 6'h01;
  localparam logic [5:0] IDX_SGN_LO = 6'h10;
  localparam logic [5:0] IDX_OFS_HI = 6'h11;
  localparam logic [5:0] IDX_OFS_LO = 6'h12;
  localparam logic [5:0] IDX_UNS_HI = 6'h31;
  localparam logic [5:0] IDX_UNS_LO = 6'h32;
  localparam logic [5:0] IDX_CTRL = 6'h3F;

  // Field positions
  localparam int INT_LSB = 5;         // Lowest integer bit inside a reading word
  localparam int FRAC_MSB = 4;        // Highest fraction bit inside a reading word
  localparam int OFS_LO_LSB = 2;      // Offset fraction bits sit at 4..2 of the low byte
  localparam int CTRL_FILT_BIT = 0;   // Filter enable in the control register

  // Values after reset
  localparam logic [7:0] OFS_HI_RST = 8'h00;
  localparam logic [2:0] OFS_LO_RST = 3'h0;
  localparam logic CTRL_FILT_RST = 1'b0;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Signed and unsigned forms of one corrected result
  typedef struct packed {
    logic [TEMP_W-1:0] sgn;           // Two's complement, saturated
    logic [TEMP_W-1:0] uns;           // Unsigned, saturated at zero and full scale
  } temp_pair_t;

  // Whole state of the register block
  typedef struct packed {
    logic [7:0] ofs_hi;               // Offset integer part
    logic [2:0] ofs_lo;               // Offset fraction part
    logic filt_en;                    // Remote filter enable
    temp_pair_t rd;                   // Latest readings
    logic [7:0] sgn_lo_snap;          // Low byte frozen at high-byte read
    logic [7:0] uns_lo_snap;
    logic aw_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane;                     // Byte lane zero was enabled
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } state_t;

endpackage

// *** hw/temp_format.sv ***
// Purpose: Adds the offset to a raw result and forms signed and unsigned readings.
// Assumes: Offset fraction step is four raw steps.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module temp_format
  import remote_temp_pkg::*;
#(
  parameter int RAW_BITS = RAW_W,
  parameter int OUT_BITS = TEMP_W,
  parameter int OFS_BITS = OFS_W
) (
  input wire logic [RAW_BITS-1:0] raw_i,
  input wire logic [OFS_BITS-1:0] offset_i,
  input wire logic filt_en_i,
  output temp_pair_t pair_o
);

  // Layout is fixed by the reading format; refuse anything else
  if (RAW_BITS != OUT_BITS + 1 || OFS_BITS + 2 != OUT_BITS || OUT_BITS != TEMP_W) begin : g_bad
    $error("temp_format: unsupported widths");
  end

  localparam int SUM_W = RAW_BITS + 1;
  localparam logic signed [SUM_W-1:0] SGN_MAX = SUM_W'((1 << (OUT_BITS - 1)) - 1);
  localparam logic signed [SUM_W-1:0] SGN_MIN = -SUM_W'(1 << (OUT_BITS - 1));
  localparam logic signed [SUM_W-1:0] UNS_MAX = SUM_W'((1 << OUT_BITS) - 1);

  logic signed [SUM_W-1:0] raw_ext;   // Raw value, sign extended
  logic signed [SUM_W-1:0] ofs_ext;   // Offset scaled to raw steps
  logic signed [SUM_W-1:0] sum;       // Corrected value
  logic [OUT_BITS-1:0] sgn_sat;
  logic [OUT_BITS-1:0] uns_sat;
  logic [OUT_BITS-1:0] keep_mask;     // Clears the filtered fraction when filter is off

  // Offset correction and saturation; one sum feeds both forms
  always_comb begin
    raw_ext = {raw_i[RAW_BITS-1], raw_i};
    ofs_ext = {{(SUM_W-OFS_BITS-2){offset_i[OFS_BITS-1]}}, offset_i, 2'b00};
    sum = raw_ext + ofs_ext;
    // Signed form clips at plus and minus full scale
    if (sum > SGN_MAX) begin
      sgn_sat = SGN_MAX[OUT_BITS-1:0];
    end else if (sum < SGN_MIN) begin
      sgn_sat = SGN_MIN[OUT_BITS-1:0];
    end else begin
      sgn_sat = sum[OUT_BITS-1:0];
    end
    // Unsigned form cannot show below zero
    if (sum < 0) begin
      uns_sat = '0;
    end else if (sum > UNS_MAX) begin
      uns_sat = UNS_MAX[OUT_BITS-1:0];
    end else begin
      uns_sat = sum[OUT_BITS-1:0];
    end
    // Extra resolution only exists when the filter runs
    keep_mask = filt_en_i ? '1 : {{(OUT_BITS-2){1'b1}}, 2'b00};
    pair_o.sgn = sgn_sat & keep_mask;
    pair_o.uns = uns_sat & keep_mask;
  end

endmodule

// *** test/remote_diode_model.sv ***
// Purpose: Converter stand-in that hands raw remote diode results to the register block.
// Assumes: A request pulse yields one result pulse on the following clock edge.
// Notes: Outside a result pulse the raw bus toggles, so stale data never looks valid.
`timescale 1ns/1ps
module remote_diode_model
  import remote_temp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic [RAW_W-1:0] value_i,
  output logic conv_valid_o,
  output logic [RAW_W-1:0] conv_raw_o
);
  // One-cycle result pulse; between pulses the bus shows the inverse of its last value
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      conv_valid_o <= 1'b0;
      conv_raw_o <= '0;
    end else begin
      conv_valid_o <= go_i;
      conv_raw_o <= go_i ? value_i : ~conv_raw_o;
    end
  end
endmodule

// *** test/remote_temp_result_offset_regs_tb_top.sv ***
// Purpose: Self-checking bench for the remote temperature result and offset registers.
// Assumes: AXI4-Lite master tasks, converter model, LFSR stimulus from a fixed seed.
// Notes: Expected readings are rebuilt from raw value, offset and filter setting.
`timescale 1ns/1ps
module remote_temp_result_offset_regs_tb_top;
  import remote_temp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic go = 1'b0;
  logic [RAW_W-1:0] value = '0;
  logic conv_valid;
  logic [RAW_W-1:0] conv_raw;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic [31:0] seed = 32'h36B501D5;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  remote_diode_model conv (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .value_i(value),
    .conv_valid_o(conv_valid), .conv_raw_o(conv_raw));

  remote_temp_regs uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .conv_valid_i(conv_valid),
    .conv_raw_i(conv_raw), .awvalid_i(awvalid), .awready_o(awready), .awaddr_i(awaddr),
    .awprot_i(3'h0), .wvalid_i(wvalid), .wready_o(wready), .wdata_i(wdata),
    .wstrb_i(wstrb), .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
    .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr), .arprot_i(3'h0),
    .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp));

  // Random source with a fixed start value
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Corrected 13-bit word; clipping keeps both formats inside their range
  function automatic logic [12:0] exp_word(input logic [13:0] raw, input logic [10:0] ofs,
                                            input logic filt, input logic uns);
    int s;
    s = $signed(raw) + $signed(ofs) * 4;
    if (uns) s = (s < 0) ? 0 : ((s > 8191) ? 8191 : s);
    else s = (s < -4096) ? -4096 : ((s > 4095) ? 4095 : s);
    if (!filt) s = s & ~3;
    return s[12:0];
  endfunction

  task automatic chk_data(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] rdata at %h expected %h seen %h", a, e, g);
    end
  endtask

  task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Write: address and data offered together, bready held until the response
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {seed[31:8], d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk_resp("bresp", er, bresp);
  endtask

  // Read: rready held until rvalid is sampled high
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk_data(a, ed, rdata);
    chk_resp("rresp", er, rresp);
  endtask

  // One conversion through the converter model
  task automatic convert(input logic [13:0] r);
    @(posedge clk_i);
    go <= 1'b1;
    value <= r;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // Program offset and filter, convert, then read both pairs high byte first
  task automatic run_case(input logic [13:0] raw, input logic [10:0] ofs, input logic f);
    logic [12:0] u;
    logic [12:0] s;
    u = exp_word(raw, ofs, f, 1'b1);
    s = exp_word(raw, ofs, f, 1'b0);
    axi_wr(8'h44, ofs[10:3], 4'hF, RESP_OKAY);
    axi_wr(8'h48, {3'h0, ofs[2:0], 2'h0}, 4'h1, RESP_OKAY);
    axi_wr(8'hFC, {7'h0, f}, 4'hF, RESP_OKAY);
    convert(raw);
    axi_rd(8'hC4, {24'h0, u[12:5]}, RESP_OKAY);
    axi_rd(8'hC8, {27'h0, u[4:0]}, RESP_OKAY);
    axi_rd(8'h04, {24'h0, s[12:5]}, RESP_OKAY);
    axi_rd(8'h40, {27'h0, s[4:0]}, RESP_OKAY);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard, far above the roughly 1200 cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    int i;
    logic [13:0] r;
    logic [12:0] w;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Values after reset
    axi_rd(8'h44, 32'h0, RESP_OKAY);
    axi_rd(8'h48, 32'h0, RESP_OKAY);
    axi_rd(8'hFC, 32'h0, RESP_OKAY);
    axi_rd(8'hC4, 32'h0, RESP_OKAY);
    $display("test reset_values done");
    // Access kinds: strobe off, unused offset bits, read-only and unmapped places
    axi_wr(8'h44, 8'hA5, 4'hF, RESP_OKAY);
    axi_rd(8'h44, 32'hA5, RESP_OKAY);
    axi_wr(8'h44, 8'h3C, 4'h0, RESP_OKAY);
    axi_rd(8'h44, 32'hA5, RESP_OKAY);
    axi_wr(8'h48, 8'hFF, 4'h1, RESP_OKAY);
    axi_rd(8'h48, 32'h1C, RESP_OKAY);
    axi_wr(8'hC4, 8'h77, 4'hF, RESP_OKAY);
    axi_rd(8'hC4, 32'h0, RESP_OKAY);
    axi_wr(8'h80, 8'h01, 4'hF, RESP_SLVERR);
    axi_rd(8'h80, 32'h0, RESP_SLVERR);
    $display("test access_kinds done");
    // Full scale, minimum, most negative offset, negative offset, unsigned overflow
    run_case(14'h1FFF, 11'h000, 1'b1);
    run_case(14'h2000, 11'h000, 1'b0);
    run_case(14'h0000, 11'h400, 1'b1);
    run_case(14'h0C80, 11'h7FF, 1'b0);
    run_case(14'h1F00, 11'h3FF, 1'b1);
    $display("test corner_cases done");
    for (i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      r = seed[13:0];
      seed = lfsr(seed);
      run_case(r, seed[10:0], seed[16]);
    end
    $display("test random_cases done");
    // A conversion between high and low reads must not split the pair
    run_case(14'h0A53, 11'h000, 1'b1);
    w = exp_word(14'h0A53, 11'h000, 1'b1, 1'b1);
    axi_rd(8'hC4, {24'h0, w[12:5]}, RESP_OKAY);
    convert(14'h1555);
    axi_rd(8'hC8, {27'h0, w[4:0]}, RESP_OKAY);
    w = exp_word(14'h1555, 11'h000, 1'b1, 1'b1);
    axi_rd(8'hC4, {24'h0, w[12:5]}, RESP_OKAY);
    axi_rd(8'hC8, {27'h0, w[4:0]}, RESP_OKAY);
    $display("test coherent_pair done");
    give_verdict();
  end
endmodule
